// ---- inc/srtr_pkg.sv ----
/*
  Shared constants and types for the self-refresh temperature and readout block.
  Assumes a 250 MHz system clock and DDR3-style command pins sampled on that clock.
*/
package srtr_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;  // Copy mode and read latency
  localparam logic [3:0] REG_STATUS = 4'h4;  // Live self-refresh state
  localparam logic [3:0] REG_MODE   = 4'h8;  // Mode register shadows
  localparam logic [3:0] REG_FLAGS  = 4'hC;  // Sticky flags, write one to clear

  // ----------------------------------------------------------------
  // Register fields and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_COPY_BIT  = 0;     // Upper DQ copy DQ0
  localparam int         CTRL_RL_LSB    = 4;     // Read latency in CK cycles
  localparam logic       CTRL_COPY_RST  = 1'b1;
  localparam logic [3:0] CTRL_RL_RST    = 4'h5;
  localparam int         STAT_RATE_BIT  = 0;     // Extended self-refresh rate
  localparam int         STAT_AUTO_BIT  = 1;     // Automatic self-refresh active
  localparam int         STAT_TEMP_BIT  = 2;     // Temperature sensor high
  localparam int         STAT_BUSY_BIT  = 3;     // Read in progress
  localparam int         MODE_BL_LSB    = 0;
  localparam int         MODE_ASR_BIT   = 2;
  localparam int         MODE_SRT_BIT   = 3;
  localparam int         MODE_MPR_BIT   = 4;
  localparam int         MODE_LOC_LSB   = 5;
  localparam int         FLAG_ILL_BIT   = 0;     // Both A6 and A7 were set
  localparam logic [1:0] MR_RST         = 2'h0;

  // ----------------------------------------------------------------
  // Command pins and mode register bits
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MRS     = 4'h0;  // cs, ras, cas, we all low
  localparam logic [3:0] CMD_READ    = 4'h5;  // cs, cas low
  localparam logic [2:0] BA_MR0      = 3'h0;
  localparam logic [2:0] BA_MR2      = 3'h2;
  localparam logic [2:0] BA_MR3      = 3'h3;
  localparam int         MR2_ASR_BIT = 6;
  localparam int         MR2_SRT_BIT = 7;
  localparam int         MR3_MPR_BIT = 2;
  localparam int         ADDR_BC_BIT = 12;
  localparam int         ADDR_A2_BIT = 2;
  localparam logic [1:0] BL_FIXED8   = 2'h0;
  localparam logic [1:0] BL_OTF      = 2'h1;
  localparam logic [1:0] BL_FIXED4   = 2'h2;

  // ----------------------------------------------------------------
  // Readout pattern and burst shape
  // ----------------------------------------------------------------
  localparam logic [1:0] LOC_CAL      = 2'h0;
  localparam logic [7:0] CAL_PATTERN  = 8'hAA;  // Beat 0 in bit 0
  localparam logic [7:0] RSV_PATTERN  = 8'h00;
  localparam logic [3:0] BEATS_FULL   = 4'h8;
  localparam logic [3:0] BEATS_CHOP   = 4'h4;
  localparam logic [2:0] BEAT_LOWER   = 3'h0;
  localparam logic [2:0] BEAT_UPPER   = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_BURST = 3'b100
  } srtr_state_type;
endpackage

// ---- inc/srtr_burst_if.sv ----
/*
  Carrier between the command decoder and the burst serializer.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface srtr_burst_if;
  logic       start;     // First beat now
  logic       full8;     // Eight beats, else four
  logic       upper;     // Chopped burst from beat 4
  logic       multi_purpose_readout;       // Pattern instead of array data
  logic       copy;      // Upper DQ copy DQ0
  logic       step;      // Any CK edge
  logic       busy;      // Burst on the pins
  logic       oe;
  logic       dqs;
  logic [7:0] pattern;
  logic [7:0] array_dq;
  logic [7:0] dq;
  modport ctl (output start, full8, upper, multi_purpose_readout, copy, step, pattern, array_dq,
               input busy, oe, dqs, dq);
  modport ser (input start, full8, upper, multi_purpose_readout, copy, step, pattern, array_dq,
               output busy, oe, dqs, dq);
endinterface

// ---- hw/srtr_burst_ser.sv ----
/*
  Burst serializer: one DQ beat per CK edge, from pattern or array data.
  Assumes start comes together with step and never during a burst.
*/
`timescale 1ns/1ps
module srtr_burst_ser (
  input wire logic   i_sys_clk,
  input wire logic   i_rst,
  srtr_burst_if.ser  bus
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] beat;     // Next burst position
    logic [3:0] left;     // Beats still to send
    logic       multi_purpose_readout;
    logic       copy;
    logic [7:0] pattern;
    logic [7:0] dq;
    logic       oe;
    logic       dqs;
  } srtr_ser_state_type;

  srtr_ser_state_type r;
  srtr_ser_state_type n;

  // Beat selection and next state
  always_comb begin
    logic [2:0] bi;
    logic       mp;
    logic       cp;
    logic [7:0] pt;
    logic       b;
    bi = r.beat;
    mp = r.multi_purpose_readout;
    cp = r.copy;
    pt = r.pattern;
    n  = r;
    if (bus.start) begin
      bi = bus.upper ? srtr_pkg::BEAT_UPPER : srtr_pkg::BEAT_LOWER;
      mp = bus.multi_purpose_readout;
      cp = bus.copy;
      pt = bus.pattern;
    end
    b = pt[bi];
    if (bus.step) begin
      if (bus.start || r.left != 4'h0) begin
        // Pattern bit on DQ0, upper lanes copy or zero
        n.dq   = mp ? {(cp ? {7{b}} : 7'h00), b} : bus.array_dq;
        n.oe   = 1'b1;
        n.dqs  = bus.start ? 1'b1 : ~r.dqs;
        n.beat = 3'(bi + 3'h1);
        n.multi_purpose_readout  = mp;
        n.copy = cp;
        n.pattern = pt;
        if (bus.start) begin
          n.left = 4'((bus.full8 ? srtr_pkg::BEATS_FULL
                                 : srtr_pkg::BEATS_CHOP) - 4'h1);
        end else begin
          n.left = 4'(r.left - 4'h1);
        end
      end else begin
        // Release pins after last beat
        n.oe  = 1'b0;
        n.dqs = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.busy = r.oe;
  assign bus.oe   = r.oe;
  assign bus.dqs  = r.dqs;
  assign bus.dq   = r.dq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_chop_len;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.step && bus.start && !bus.full8 |=> r.left == 4'h3 && r.oe;
  endproperty
  a_chop_len: assert property (p_chop_len) else $error("chop length wrong");

  property p_first_bit;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.step && bus.start && bus.multi_purpose_readout && bus.upper
      |=> bus.dq[0] == $past(bus.pattern[4]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("upper nibble order wrong");

  property p_copy;
    @(posedge i_sys_clk) disable iff (i_rst)
      $rose(r.oe) && r.multi_purpose_readout |-> bus.dq[7:1] == (r.copy ? {7{bus.dq[0]}} : 7'h00);
  endproperty
  a_copy: assert property (p_copy) else $error("upper DQ lanes wrong");

  c_full: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    bus.start && bus.full8 && bus.multi_purpose_readout);
  c_upper: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    bus.start && bus.upper);
endmodule

// ---- hw/srtr_top.sv ----
/*
  Self-refresh temperature options and readout-register reads of a DDR3 device.
  Assumes a controller on CK pins (sampled here on the system clock),
  an Avalon-MM master for the registers, and a same-clock array data source.
*/
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
// What this block does
// - A6 set, A7 clear enables automatic self-refresh
// - A7 selects normal or extended range
// - Automatic mode tracks temperature for refresh
// - Range bit picks normal or extended rate
// - MR3 A2 clear: reads from array
// - MR3 A2 set: reads return selected location
// - DQ0 carries bit; others copy or zero
// - A2 picks lower or upper chopped nibble
// - Burst chop by pin or mode register
// - Bank and high column bits ignored
// - Readout reads use ordinary read latency
// - Beat zero is LSB, seven MSB
// - Location zero returns alternating calibration pattern
// - Chop pin low four beats, high eight
`timescale 1ns/1ps
module srtr_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_ck,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_ba,
  input  wire logic [13:0] i_addr,
  input  wire logic        i_temp_high,
  input  wire logic [7:0]  i_array_dq,
  output logic      [7:0]  o_dq,
  output logic             o_dq_oe,
  output logic             o_dqs,
  output logic             o_sr_rate_ext,
  output logic             o_sr_auto
);
  localparam int PIN_W = 21;  // Command, bank and address pins

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                     ck_m;      // CK first sync stage
    logic                     ck_s;      // CK second sync stage
    logic                     ck_d;      // CK edge history
    logic [PIN_W-1:0]         pin_m;     // Pins first sync stage
    logic [PIN_W-1:0]         pin_s;     // Pins second sync stage
    logic                     temp_m;
    logic                     temp_s;
    logic [1:0]               bl;        // MR0 burst length field
    logic                     auto_selfrefresh_enable;       // auto_selfrefresh_enable
    logic                     selfref_temp_range_select;       // selfref_temp_range_select
    logic                     multi_purpose_readout;       // multi_purpose_readout enable
    logic [1:0]               loc;       // Readout location
    logic                     copy;
    logic [3:0]               rl;
    logic                     illegal;
    srtr_pkg::srtr_state_type st;
    logic [3:0]               lat;       // CK rises left to data
    logic                     full8;
    logic                     upper;
    logic                     wait_r;
    logic [31:0]              rdata;
    logic                     rate_ext;
    logic                     auto_sr;
  } srtr_top_state_type;

  srtr_top_state_type r;
  srtr_top_state_type n;
  srtr_burst_if       bus ();

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic        ck_rise;     // Command sample point
  logic        ck_fall;
  logic [3:0]  cmd;         // cs, ras, cas, we
  logic [2:0]  ba;
  logic [13:0] a;
  logic        is_mrs;
  logic        read_acc;    // Read taken in idle
  logic        req;         // Bus request
  logic        ill_set;     // Both A6 and A7 written
  logic        ill_clr;

  // Edge and command decode on the synchronized pins
  always_comb begin
    ck_rise  = r.ck_s & ~r.ck_d;
    ck_fall  = ~r.ck_s & r.ck_d;
    cmd      = r.pin_s[20:17];
    ba       = r.pin_s[16:14];
    a        = r.pin_s[13:0];
    is_mrs   = ck_rise && cmd == srtr_pkg::CMD_MRS;
    read_acc = ck_rise && cmd == srtr_pkg::CMD_READ && r.st == srtr_pkg::ST_IDLE;
    req      = i_avs_read | i_avs_write;
    ill_set  = is_mrs && ba == srtr_pkg::BA_MR2
               && a[srtr_pkg::MR2_ASR_BIT] && a[srtr_pkg::MR2_SRT_BIT];
    ill_clr  = i_avs_write && !r.wait_r && i_avs_address == srtr_pkg::REG_FLAGS
               && i_avs_byteenable[0] && i_avs_writedata[srtr_pkg::FLAG_ILL_BIT];
  end

  // Read mux for the register bus
  function automatic logic [31:0] reg_read(input srtr_top_state_type s,
                                           input logic [3:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (addr)
      srtr_pkg::REG_CTRL: begin
        d[srtr_pkg::CTRL_COPY_BIT]     = s.copy;
        d[srtr_pkg::CTRL_RL_LSB +: 4]  = s.rl;
      end
      srtr_pkg::REG_STATUS: begin
        d[srtr_pkg::STAT_RATE_BIT] = s.rate_ext;
        d[srtr_pkg::STAT_AUTO_BIT] = s.auto_sr;
        d[srtr_pkg::STAT_TEMP_BIT] = s.temp_s;
        d[srtr_pkg::STAT_BUSY_BIT] = s.st != srtr_pkg::ST_IDLE;
      end
      srtr_pkg::REG_MODE: begin
        d[srtr_pkg::MODE_BL_LSB +: 2]  = s.bl;
        d[srtr_pkg::MODE_ASR_BIT]      = s.auto_selfrefresh_enable;
        d[srtr_pkg::MODE_SRT_BIT]      = s.selfref_temp_range_select;
        d[srtr_pkg::MODE_MPR_BIT]      = s.multi_purpose_readout;
        d[srtr_pkg::MODE_LOC_LSB +: 2] = s.loc;
      end
      srtr_pkg::REG_FLAGS: begin
        d[srtr_pkg::FLAG_ILL_BIT] = s.illegal;
      end
      default: begin
        // Unmapped offsets read zero
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // Two-stage synchronizers for everything off the pins
    n.ck_m   = i_ck;
    n.ck_s   = r.ck_m;
    n.ck_d   = r.ck_s;
    n.pin_m  = {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};
    n.pin_s  = r.pin_m;
    n.temp_m = i_temp_high;
    n.temp_s = r.temp_m;

    // Mode register set commands
    if (is_mrs) begin
      if (ba == srtr_pkg::BA_MR0) begin
        n.bl = a[1:0];
      end else if (ba == srtr_pkg::BA_MR2) begin
        n.auto_selfrefresh_enable = a[srtr_pkg::MR2_ASR_BIT];
        n.selfref_temp_range_select = a[srtr_pkg::MR2_SRT_BIT];
      end else if (ba == srtr_pkg::BA_MR3) begin
        n.multi_purpose_readout = a[srtr_pkg::MR3_MPR_BIT];
        n.loc = a[1:0];
      end
    end

    // Illegal combination stays visible until cleared; a new one wins
    n.illegal = (r.illegal & ~ill_clr) | ill_set;

    // Self-refresh rate: sensor in automatic mode, range bit otherwise
    n.rate_ext = r.auto_selfrefresh_enable ? r.temp_s : r.selfref_temp_range_select;
    n.auto_sr  = r.auto_selfrefresh_enable & ~r.selfref_temp_range_select;

    // Read sequencing
    unique case (r.st)
      srtr_pkg::ST_IDLE: begin
        if (read_acc) begin
          // Same latency path for array and readout reads
          n.st  = srtr_pkg::ST_WAIT;
          n.lat = (r.rl == 4'h0) ? 4'h1 : r.rl;
          // Burst chop from MR0 or from the chop pin
          if (r.bl == srtr_pkg::BL_OTF) begin
            n.full8 = a[srtr_pkg::ADDR_BC_BIT];
          end else begin
            n.full8 = r.bl != srtr_pkg::BL_FIXED4;
          end
          // Only A2 picks the nibble; bank and other columns unused
          n.upper = r.bl == srtr_pkg::BL_FIXED4 ? a[srtr_pkg::ADDR_A2_BIT]
                  : (r.bl == srtr_pkg::BL_OTF && !a[srtr_pkg::ADDR_BC_BIT]
                     && a[srtr_pkg::ADDR_A2_BIT]);
        end
      end
      srtr_pkg::ST_WAIT: begin
        if (ck_rise) begin
          if (r.lat == 4'h1) begin
            n.st = srtr_pkg::ST_BURST;
          end else begin
            n.lat = 4'(r.lat - 4'h1);
          end
        end
      end
      srtr_pkg::ST_BURST: begin
        // Wait for serializer to release pins
        if (!bus.busy) begin
          n.st = srtr_pkg::ST_IDLE;
        end
      end
    endcase

    // Avalon slave: one wait cycle per request
    n.wait_r = !(req && r.wait_r);
    if (i_avs_read && r.wait_r) begin
      n.rdata = reg_read(r, i_avs_address);
    end
    if (i_avs_write && !r.wait_r
        && i_avs_address == srtr_pkg::REG_CTRL && i_avs_byteenable[0]) begin
      n.copy = i_avs_writedata[srtr_pkg::CTRL_COPY_BIT];
      n.rl   = i_avs_writedata[srtr_pkg::CTRL_RL_LSB +: 4];
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r        <= '0;
      r.bl     <= srtr_pkg::MR_RST;
      r.loc    <= srtr_pkg::MR_RST;
      r.copy   <= srtr_pkg::CTRL_COPY_RST;
      r.rl     <= srtr_pkg::CTRL_RL_RST;
      r.st     <= srtr_pkg::ST_IDLE;
      r.wait_r <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Burst serializer hookup
  // ----------------------------------------------------------------
  assign bus.start    = ck_rise && r.st == srtr_pkg::ST_WAIT && r.lat == 4'h1;
  assign bus.step     = ck_rise | ck_fall;
  assign bus.full8    = r.full8;
  assign bus.upper    = r.upper;
  assign bus.multi_purpose_readout      = r.multi_purpose_readout;
  assign bus.copy     = r.copy;
  assign bus.array_dq = i_array_dq;
  assign bus.pattern  = (r.loc == srtr_pkg::LOC_CAL) ? srtr_pkg::CAL_PATTERN
                                                     : srtr_pkg::RSV_PATTERN;

  srtr_burst_ser u_ser (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (bus.ser)
  );

  assign o_dq              = bus.dq;
  assign o_dq_oe           = bus.oe;
  assign o_dqs             = bus.dqs;
  assign o_avs_readdata    = r.rdata;
  assign o_avs_waitrequest = r.wait_r;
  assign o_sr_rate_ext     = r.rate_ext;
  assign o_sr_auto         = r.auto_sr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mr3_set;
    @(posedge i_sys_clk) disable iff (i_rst)
      is_mrs && ba == srtr_pkg::BA_MR3 |=> r.multi_purpose_readout == $past(a[2]) && r.loc == $past(a[1:0]);
  endproperty
  a_mr3_set: assert property (p_mr3_set) else $error("MR3 not captured");

  property p_illegal;
    @(posedge i_sys_clk) disable iff (i_rst)
      ill_set |=> r.illegal && r.auto_selfrefresh_enable && r.selfref_temp_range_select;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal combo missed");

  property p_auto_rate;
    @(posedge i_sys_clk) disable iff (i_rst)
      r.auto_selfrefresh_enable && $stable(r.auto_selfrefresh_enable) ##1 $stable(r.auto_selfrefresh_enable) |-> o_sr_rate_ext == $past(r.temp_s);
  endproperty
  a_auto_rate: assert property (p_auto_rate) else $error("auto rate wrong");

  property p_manual_rate;
    @(posedge i_sys_clk) disable iff (i_rst)
      !r.auto_selfrefresh_enable ##1 !r.auto_selfrefresh_enable |-> o_sr_rate_ext == $past(r.selfref_temp_range_select) && !o_sr_auto;
  endproperty
  a_manual_rate: assert property (p_manual_rate) else $error("manual rate wrong");

  property p_wait_one;
    @(posedge i_sys_clk) disable iff (i_rst)
      req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing");

  property p_latency;
    @(posedge i_sys_clk) disable iff (i_rst)
      read_acc |-> ##[1:1000] bus.start;
  endproperty
  a_latency: assert property (p_latency) else $error("read never started");

  property p_array;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.start && !r.multi_purpose_readout |=> o_dq == $past(i_array_dq) && o_dq_oe;
  endproperty
  a_array: assert property (p_array) else $error("array data not driven");

  property p_cal_first;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.start && r.multi_purpose_readout && r.loc == srtr_pkg::LOC_CAL && !r.upper
      |=> !o_dq[0] ##[1:80] o_dq[0];
  endproperty
  a_cal_first: assert property (p_cal_first) else $error("pattern order wrong");

  c_illegal: cover property (@(posedge i_sys_clk) disable iff (i_rst) ill_set);
  c_array: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    bus.start && !r.multi_purpose_readout);
endmodule

// ---- tb/srtr_ctl_model.sv ----
/*
  Controller model: drives CK and the command pins, one command per frame.
  Assumes the device samples the pins at each CK rise.
*/
`timescale 1ns/1ps
module srtr_ctl_model (
  output logic        o_ck,
  output logic        o_cs_n,
  output logic        o_ras_n,
  output logic        o_cas_n,
  output logic        o_we_n,
  output logic [2:0]  o_ba,
  output logic [13:0] o_addr
);
  time t_rise;  // Time of the last command rise
  // No refresh or self refresh is issued; reads follow lock
  initial begin
    {o_ck, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h0F;
    o_ba = 3'h0;
    o_addr = 14'h0;
  end
  // Command at one rise, then n idle CK cycles; CK stands still after
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                     input int n);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_ba = b;
    o_addr = a;
    #80 o_ck = 1'b1;
    t_rise = $time;
    #80 o_ck = 1'b0;
    // Released command pins go high; bank and address pins show the inverse of the last value
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_ba = ~b;
    o_addr = ~a;
    repeat (n) begin
      #80 o_ck = 1'b1;
      #80 o_ck = 1'b0;
    end
  endtask
endmodule

// ---- tb/srtr_top_tb.sv ----
/*
  Testbench: Avalon tasks, mode register commands and readout bursts.
  Assumes the controller model drives CK and the command pins.
*/
`timescale 1ns/1ps
module srtr_top_tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_avs_address = 4'h0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic        i_temp_high = 1'b0;
  logic [7:0]  i_array_dq = 8'h5A;
  logic [3:0]  i_avs_byteenable = 4'hF;  // Byte lane enables, lane 0 gates writes
  logic [31:0] o_avs_readdata, q;
  logic        o_avs_waitrequest, o_dq_oe, o_dqs, o_sr_rate_ext, o_sr_auto, oe_q, dqs_q;
  logic [7:0]  o_dq;
  logic        ck, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic [7:0]  beats[$];  // Captured burst beats
  time         t_first;   // Time of the first beat
  logic        dqs_first; // Strobe level on the first beat
  int          fails = 0;
  int          comparisons = 0;
  // 250 MHz system clock
  always #2 i_sys_clk = ~i_sys_clk;
  srtr_ctl_model i_ctl (.o_ck(ck), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
                        .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
  srtr_top i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_ck(ck), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_temp_high(i_temp_high),
    .i_array_dq(i_array_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs),
    .o_sr_rate_ext(o_sr_rate_ext), .o_sr_auto(o_sr_auto));
  // Beat capture: new beat on enable rise or strobe change
  always @(posedge i_sys_clk) begin
    if (o_dq_oe === 1'b1 && (oe_q !== 1'b1 || o_dqs !== dqs_q)) begin
      if (oe_q !== 1'b1) begin
        t_first = $time;
        dqs_first = o_dqs;
      end
      beats.push_back(o_dq);
    end
    oe_q <= o_dq_oe;
    dqs_q <= o_dqs;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h1, 32'h0);
  endtask
  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    i_ctl.cmd(srtr_pkg::CMD_MRS, b, a, 2);
  endtask
  // Read burst of n beats from beat b0; bank and high column bits set
  task automatic rd(input logic [13:0] a, input int n, input int b0, input logic m,
                    input logic [1:0] loc, input logic cp);
    logic bt;
    beats.delete();
    i_ctl.cmd(srtr_pkg::CMD_READ, 3'h7, a | 14'h2FF8, 12);
    chk("beats", beats.size(), n);
    chk("latency", 32'((t_first - i_ctl.t_rise) / 160), 32'h5);
    chk("dqs_first", dqs_first, 32'h1);
    for (int k = 0; k < n && k < beats.size(); k++) begin
      bt = m && loc == 2'h0 && (b0 + k) % 2 == 1;
      chk("beat", beats[k], m ? (cp ? {8{bt}} : {7'h0, bt}) : 8'h5A);
    end
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    av(1'b0, 4'h0, 32'h0);
    chk("ctrl", q, 32'h51);
    av(1'b0, 4'h8, 32'h0);
    chk("mode", q, 32'h0);
    av(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    mrs(3'h0, 14'h0);
    // Every A6/A7 pair at both temperatures
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge i_sys_clk);
        i_temp_high <= t[0];
        mrs(srtr_pkg::BA_MR2, {6'h0, m[1:0], 6'h0});
        chk("auto", o_sr_auto, m == 1);
        chk("rate", o_sr_rate_ext, m[0] ? t[0] : m[1]);
      end
    end
    av(1'b0, 4'h4, 32'h0);
    chk("status", q, 32'h5);
    av(1'b0, 4'hC, 32'h0);
    chk("illegal", q, 32'h1);
    av(1'b1, 4'hC, 32'h1);
    av(1'b0, 4'hC, 32'h0);
    chk("cleared", q, 32'h0);
    mrs(srtr_pkg::BA_MR2, 14'h0);
    mrs(srtr_pkg::BA_MR0, 14'h1);
    mrs(srtr_pkg::BA_MR3, 14'h4);
    rd(14'h1000, 8, 0, 1'b1, 2'h0, 1'b1);
    rd(14'h0004, 4, 4, 1'b1, 2'h0, 1'b1);
    mrs(srtr_pkg::BA_MR0, 14'h2);
    rd(14'h1000, 4, 0, 1'b1, 2'h0, 1'b1);
    mrs(srtr_pkg::BA_MR0, 14'h1);
    av(1'b1, 4'h0, 32'h50);
    i_avs_byteenable <= 4'h0;
    av(1'b1, 4'h0, 32'h01);
    i_avs_byteenable <= 4'hF;
    av(1'b0, 4'h0, 32'h0);
    chk("ctrl_be", q, 32'h50);
    rd(14'h1000, 8, 0, 1'b1, 2'h0, 1'b0);
    mrs(srtr_pkg::BA_MR3, 14'h5);
    rd(14'h1000, 8, 0, 1'b1, 2'h1, 1'b0);
    mrs(srtr_pkg::BA_MR3, 14'h3);
    rd(14'h1000, 8, 0, 1'b0, 2'h3, 1'b0);
    complete_run();
  end
endmodule
